// ===== core/slot_policy_pkg.sv
// constants, encodings and types shared by the slot policy block
// assumes a single 200 MHz clock domain; no timing counts are needed
package slot_policy_pkg;

    // --------------------------------------------------------------
    // data slots
    // --------------------------------------------------------------
    localparam logic [3:0] SLOT_GENERAL = 4'h8;
    localparam logic [3:0] SLOT_AES = 4'h9;
    localparam logic [3:0] SLOT_DEV_CERT = 4'ha;
    localparam logic [3:0] SLOT_SIGNER_KEY = 4'hb;
    localparam logic [3:0] SLOT_SIGNER_CERT = 4'hc;
    localparam int WORD_BITS = 32;
    localparam int SLOT_WORDS = 16;
    localparam int AES_KEY_COUNT = 4;
    localparam int AES_KEY_BITS = 128;

    // --------------------------------------------------------------
    // one-time-programmable zone
    // --------------------------------------------------------------
    localparam int OTP_BYTES = 64;
    localparam int OTP_BLOCK_BYTES = 32;
    localparam int OTP_BITS = OTP_BYTES * 8;
    localparam logic OTP_LOCKED_RST = 1'b1;
    localparam logic [3:0] BURST_LAST = 4'(OTP_BLOCK_BYTES / 4 - 1);

    // --------------------------------------------------------------
    // storage map, words of 32 bits
    // --------------------------------------------------------------
    localparam int MEM_AW = 7;
    localparam int MEM_DEPTH = 128;
    localparam int SCRATCH_KEY_BYTES = 64;
    localparam int DIGEST_BYTES = 64;
    localparam int ALT_KEY_BYTES = 32;
    localparam logic [MEM_AW-1:0] SCRATCH_KEY_BASE = 7'h50;
    localparam logic [MEM_AW-1:0] DIGEST_BASE = 7'h60;
    localparam logic [MEM_AW-1:0] ALTKEY_BASE = 7'h70;

    // --------------------------------------------------------------
    // status codes and hash constants
    // --------------------------------------------------------------
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_PARSE = 8'h03;
    localparam logic [7:0] STATUS_DENIED = 8'h0f;
    localparam logic [31:0] HASH_IV = 32'h6a09e667;
    localparam logic [31:0] DERIVE_TWEAK = 32'h3c3c3c3c;
    localparam logic [1:0] HASH_INIT = 2'h0;
    localparam logic [1:0] HASH_UPDATE = 2'h1;
    localparam logic [1:0] HASH_FINAL_BUF = 2'h2;
    localparam logic [1:0] HASH_FINAL_OUT = 2'h3;

    // --------------------------------------------------------------
    // commands and states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_READ = 4'h0,
        CMD_WRITE = 4'h1,
        CMD_LOCK = 4'h2,
        CMD_DIGEST_GEN = 4'h3,
        CMD_MAC = 4'h4,
        CMD_AES = 4'h5,
        CMD_VERIFY = 4'h6,
        CMD_KEY_GEN_PUB = 4'h7,
        CMD_CHECKMAC_COPY = 4'h8,
        CMD_HASH = 4'h9,
        CMD_SEED_LOAD = 4'ha,
        CMD_KEY_DERIVE = 4'hb
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE = 2'b11
    } state_t;

endpackage : slot_policy_pkg

// ===== core/slot_store_ram.sv
// single-port word store for data slots and internal scratch buffers
// assumes the caller never reads and writes in the same cycle
`timescale 1ns/1ps
module slot_store_ram
    import slot_policy_pkg::*;
(
    // clock
    input wire logic clk,
    // access
    input wire logic we,
    input wire logic re,
    input wire logic [MEM_AW-1:0] addr,
    input wire logic [WORD_BITS-1:0] wdata,
    output logic [WORD_BITS-1:0] rdata_ff
);

    logic [WORD_BITS-1:0] mem [MEM_DEPTH];

    // --------------------------------------------------------------
    // write port
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // --------------------------------------------------------------
    // registered read port
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (re) begin
            rdata_ff <= mem[addr];
        end
    end

endmodule : slot_store_ram

// ===== core/secure_slot_access_policy.sv
// access policy for data slots 8 to 12, locked otp zone and scratch buffers
// assumes commands come from same-clock framing logic; one at a time
`timescale 1ns/1ps
module secure_slot_access_policy
    import slot_policy_pkg::*;
#(
    // otp contents; value is arbitrary
    parameter logic [OTP_BITS-1:0] OTP_IMAGE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [1:0] cmd_mode,
    input wire logic cmd_otp,
    input wire logic [3:0] cmd_slot,
    input wire logic [3:0] cmd_word,
    input wire logic [1:0] cmd_key,
    input wire logic cmd_burst,
    input wire logic [WORD_BITS-1:0] cmd_wdata,
    output logic cmd_ready_ff,
    // response
    output logic rsp_valid_ff,
    output logic rsp_last_ff,
    output logic [7:0] rsp_status_ff,
    output logic [WORD_BITS-1:0] rsp_rdata_ff,
    // power
    input wire logic sleep_req,
    // status
    output logic slot8_locked_ff,
    output logic otp_locked_ff,
    output logic scratch_key_valid_ff,
    output logic digest_valid_ff,
    output logic altkey_valid_ff,
    output logic hash_active_ff
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [MEM_AW-1:0] slot_addr(input logic [3:0] slot,
                                                  input logic [3:0] word);
        logic [3:0] idx;
        idx = slot - SLOT_GENERAL;
        slot_addr = {idx[2:0], word};
    endfunction : slot_addr

    function automatic logic [WORD_BITS-1:0] mix_word(input logic [WORD_BITS-1:0] a,
                                                    input logic [WORD_BITS-1:0] b);
        mix_word = {a[26:0], a[31:27]} ^ b;
    endfunction : mix_word

    state_t state_ff;
    state_t nxt_state;
    logic take;
    logic permit;
    logic malformed;
    logic granted;
    logic fetch;
    logic copy;
    logic to_alt;
    logic mixed;
    logic [MEM_AW-1:0] src_addr;
    logic [MEM_AW-1:0] dst_addr;
    logic mem_we;
    logic mem_re;
    logic [MEM_AW-1:0] mem_addr;
    logic [WORD_BITS-1:0] mem_wdata;
    logic [WORD_BITS-1:0] mem_rdata;
    logic [WORD_BITS-1:0] src_data;
    logic [3:0] otp_idx;
    logic [WORD_BITS-1:0] otp_q_ff;
    logic [3:0] rd_left_ff;
    logic [MEM_AW-1:0] rd_ptr_ff;
    logic rd_otp_ff;
    logic copy_ff;
    logic to_alt_ff;
    logic mix_ff;
    logic [MEM_AW-1:0] dst_ff;
    logic [WORD_BITS-1:0] hash_ctx_ff;
    logic hash_cmd;

    assign take = cmd_valid && cmd_ready_ff;
    assign granted = take && permit && !malformed;
    assign hash_cmd = granted && (cmd_op == CMD_HASH);

    // --------------------------------------------------------------
    // policy decode
    // --------------------------------------------------------------
    always_comb begin
        permit = 1'b0;
        malformed = 1'b0;
        fetch = 1'b0;
        copy = 1'b0;
        to_alt = 1'b0;
        mixed = 1'b0;
        src_addr = slot_addr(cmd_slot, cmd_word);
        dst_addr = SCRATCH_KEY_BASE | {3'h0, cmd_word};
        case (cmd_op)
            CMD_READ: begin
                fetch = 1'b1;
                if (cmd_burst && (cmd_word[2:0] != 3'h0)) begin
                    malformed = 1'b1;
                end
                // clear reads; never slot 9 or scratch
                permit = cmd_otp || (cmd_slot == SLOT_GENERAL) ||
                         (cmd_slot == SLOT_DEV_CERT) || (cmd_slot == SLOT_SIGNER_KEY) ||
                         (cmd_slot == SLOT_SIGNER_CERT);
            end
            CMD_WRITE: begin
                permit = !cmd_otp && (((cmd_slot == SLOT_GENERAL) && !slot8_locked_ff) ||
                         (cmd_slot == SLOT_AES));
            end
            CMD_LOCK: begin
                permit = !cmd_otp && (cmd_slot == SLOT_GENERAL) && !slot8_locked_ff;
            end
            CMD_DIGEST_GEN: begin
                fetch = 1'b1;
                copy = 1'b1;
                permit = !cmd_otp && ((cmd_slot == SLOT_GENERAL) ||
                         (cmd_slot == SLOT_DEV_CERT) || (cmd_slot == SLOT_SIGNER_KEY) ||
                         (cmd_slot == SLOT_SIGNER_CERT));
            end
            CMD_MAC: begin
                fetch = 1'b1;
                copy = 1'b1;
                permit = !cmd_otp && (cmd_slot >= SLOT_GENERAL) &&
                         (cmd_slot <= SLOT_SIGNER_CERT);
            end
            CMD_AES: begin
                fetch = 1'b1;
                copy = 1'b1;
                src_addr = slot_addr(SLOT_AES, {cmd_key, cmd_word[1:0]});
                permit = !cmd_otp && (cmd_slot == SLOT_AES);
            end
            CMD_VERIFY: begin
                // key from slot 11, digest from buffer
                permit = !cmd_otp && (cmd_slot == SLOT_SIGNER_KEY) && digest_valid_ff;
            end
            CMD_KEY_GEN_PUB: begin
                fetch = 1'b1;
                copy = 1'b1;
                permit = !cmd_otp && (cmd_slot == SLOT_SIGNER_KEY);
            end
            CMD_CHECKMAC_COPY: begin
                // no copy source in this range
                permit = 1'b0;
            end
            CMD_HASH: begin
                // update and finalize need an open context
                permit = (cmd_mode == HASH_INIT) || hash_active_ff;
            end
            CMD_SEED_LOAD: begin
                permit = 1'b1;
            end
            CMD_KEY_DERIVE: begin
                fetch = 1'b1;
                copy = 1'b1;
                to_alt = 1'b1;
                mixed = 1'b1;
                src_addr = SCRATCH_KEY_BASE | {3'h0, cmd_word};
                dst_addr = ALTKEY_BASE | {4'h0, cmd_word[2:0]};
                permit = scratch_key_valid_ff;
            end
            default: begin
                malformed = 1'b1;
            end
        endcase
    end

    // --------------------------------------------------------------
    // state machine
    // --------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = (granted && fetch) ? ST_FETCH : ST_DONE;
                end
            end
            ST_FETCH: begin
                if (copy_ff || (rd_left_ff == 4'h0)) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ready_ff <= 1'b0;
        end else begin
            cmd_ready_ff <= (nxt_state == ST_IDLE);
        end
    end

    // --------------------------------------------------------------
    // storage port control
    // --------------------------------------------------------------
    assign src_data = rd_otp_ff ? otp_q_ff : mem_rdata;

    always_comb begin
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_addr = src_addr;
        mem_wdata = cmd_wdata;
        if ((state_ff == ST_IDLE) && granted) begin
            case (cmd_op)
                CMD_WRITE: begin
                    mem_we = 1'b1;
                end
                CMD_SEED_LOAD: begin
                    mem_we = 1'b1;
                    mem_addr = ALTKEY_BASE | {4'h0, cmd_word[2:0]};
                end
                CMD_HASH: begin
                    mem_we = (cmd_mode == HASH_FINAL_BUF);
                    mem_addr = DIGEST_BASE;
                    mem_wdata = hash_ctx_ff;
                end
                default: begin
                    mem_re = fetch && !cmd_otp;
                end
            endcase
        end else if (state_ff == ST_FETCH) begin
            if (copy_ff) begin
                // source word lands in a scratch buffer
                mem_we = 1'b1;
                mem_addr = dst_ff;
                mem_wdata = mix_ff ? mix_word(src_data, DERIVE_TWEAK) : src_data;
            end else if ((rd_left_ff != 4'h0) && !rd_otp_ff) begin
                mem_re = 1'b1;
                mem_addr = rd_ptr_ff;
            end
        end
    end

    slot_store_ram u_store (
        .clk(clk),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata_ff(mem_rdata)
    );

    // --------------------------------------------------------------
    // otp read-only lookup
    // --------------------------------------------------------------
    assign otp_idx = (state_ff == ST_IDLE) ? cmd_word : rd_ptr_ff[3:0];

    always_ff @(posedge clk) begin
        otp_q_ff <= OTP_IMAGE[{otp_idx, 5'h00} +: WORD_BITS];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otp_locked_ff <= OTP_LOCKED_RST;
        end else begin
            otp_locked_ff <= OTP_LOCKED_RST;
        end
    end

    // --------------------------------------------------------------
    // transfer bookkeeping
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_left_ff <= 4'h0;
            rd_ptr_ff <= '0;
            rd_otp_ff <= 1'b0;
            copy_ff <= 1'b0;
            to_alt_ff <= 1'b0;
            mix_ff <= 1'b0;
            dst_ff <= '0;
        end else if ((state_ff == ST_IDLE) && granted && fetch) begin
            rd_left_ff <= ((cmd_op == CMD_READ) && cmd_burst) ? BURST_LAST : 4'h0;
            rd_ptr_ff <= cmd_otp ? MEM_AW'({3'h0, cmd_word} + 7'h01) :
                         MEM_AW'(src_addr + 7'h01);
            rd_otp_ff <= cmd_otp;
            copy_ff <= copy;
            to_alt_ff <= to_alt;
            mix_ff <= mixed;
            dst_ff <= dst_addr;
        end else if ((state_ff == ST_FETCH) && !copy_ff && (rd_left_ff != 4'h0)) begin
            rd_left_ff <= rd_left_ff - 4'h1;
            rd_ptr_ff <= MEM_AW'(rd_ptr_ff + 7'h01);
        end
    end

    // --------------------------------------------------------------
    // response
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_last_ff <= 1'b0;
            rsp_status_ff <= STATUS_OK;
            rsp_rdata_ff <= '0;
        end else if ((state_ff == ST_IDLE) && take && !(granted && fetch)) begin
            rsp_valid_ff <= 1'b1;
            rsp_last_ff <= 1'b1;
            // refused command reports error, no result
            rsp_status_ff <= malformed ? STATUS_PARSE : (permit ? STATUS_OK : STATUS_DENIED);
            rsp_rdata_ff <= (hash_cmd && (cmd_mode == HASH_FINAL_OUT)) ? hash_ctx_ff : '0;
        end else if (state_ff == ST_FETCH) begin
            rsp_valid_ff <= 1'b1;
            rsp_last_ff <= copy_ff || (rd_left_ff == 4'h0);
            rsp_status_ff <= STATUS_OK;
            rsp_rdata_ff <= copy_ff ? '0 : src_data;
        end else begin
            rsp_valid_ff <= 1'b0;
            rsp_last_ff <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // slot lock
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot8_locked_ff <= 1'b0;
        end else if (granted && (cmd_op == CMD_LOCK)) begin
            slot8_locked_ff <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // scratch validity
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scratch_key_valid_ff <= 1'b0;
        end else if ((state_ff == ST_FETCH) && copy_ff && !to_alt_ff) begin
            scratch_key_valid_ff <= 1'b1;
        end else if (sleep_req) begin
            scratch_key_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            altkey_valid_ff <= 1'b0;
        end else if (((state_ff == ST_FETCH) && copy_ff && to_alt_ff) ||
                     (granted && (cmd_op == CMD_SEED_LOAD))) begin
            altkey_valid_ff <= 1'b1;
        end else if (sleep_req) begin
            altkey_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digest_valid_ff <= 1'b0;
        end else if (hash_cmd && (cmd_mode == HASH_FINAL_BUF)) begin
            digest_valid_ff <= 1'b1;
        end else if (sleep_req) begin
            digest_valid_ff <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // hash context
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hash_active_ff <= 1'b0;
            hash_ctx_ff <= '0;
        end else if (hash_cmd) begin
            case (cmd_mode)
                HASH_INIT: begin
                    hash_active_ff <= 1'b1;
                    hash_ctx_ff <= HASH_IV;
                end
                HASH_UPDATE: begin
                    hash_ctx_ff <= mix_word(hash_ctx_ff, cmd_wdata);
                end
                default: begin
                    hash_active_ff <= 1'b0;
                end
            endcase
        end else if (sleep_req) begin
            hash_active_ff <= 1'b0;
            hash_ctx_ff <= '0;
        end
    end

endmodule : secure_slot_access_policy

// ===== verif/slot_policy_props.sv
// assertions on the ports of the slot policy block
// assumes bind into secure_slot_access_policy, one clock domain
`timescale 1ns/1ps
module slot_policy_props
    import slot_policy_pkg::*;
(
    // block ports
    input wire logic clk, rst, cmd_valid, cmd_otp, cmd_burst, sleep_req,
    input wire logic [3:0] cmd_op, cmd_slot, cmd_word,
    input wire logic cmd_ready_ff, rsp_valid_ff, rsp_last_ff, slot8_locked_ff,
    input wire logic otp_locked_ff, scratch_key_valid_ff, digest_valid_ff,
    input wire logic altkey_valid_ff, hash_active_ff,
    input wire logic [7:0] rsp_status_ff,
    input wire logic [WORD_BITS-1:0] rsp_rdata_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic tk = cmd_valid && cmd_ready_ff;
    wire logic wr = tk && cmd_op == CMD_WRITE;
    wire logic dn = rsp_valid_ff && rsp_status_ff == STATUS_DENIED;
    // ----
    // checks
    // ----
    otp_locked_a:
        assert property (otp_locked_ff) else $error("otp unlocked");
    otp_write_a:
        assert property (wr && cmd_otp |=> dn) else $error("otp write taken");
    cert_write_a:
        assert property (wr && !cmd_otp && cmd_slot inside {[4'ha:4'hc]} |=> dn)
            else $error("cert write taken");
    slot8_write_a:
        assert property (wr && !cmd_otp && cmd_slot == SLOT_GENERAL && !slot8_locked_ff
            |=> rsp_valid_ff && rsp_status_ff == STATUS_OK) else $error("slot 8 write refused");
    copy_deny_a:
        assert property (tk && cmd_op == CMD_CHECKMAC_COPY |=> dn) else $error("copy taken");
    secret_read_a:
        assert property (tk && cmd_op == CMD_READ && !cmd_otp && cmd_slot == SLOT_AES
            && !cmd_burst |=> dn) else $error("slot 9 read");
    deny_quiet_a:
        assert property (dn |-> rsp_last_ff && rsp_rdata_ff == '0) else $error("denied data");
    sleep_clear_a:
        assert property (sleep_req && cmd_ready_ff && !cmd_valid |=> !(scratch_key_valid_ff
            || digest_valid_ff || altkey_valid_ff || hash_active_ff)) else $error("sleep kept");
    otp_burst_a:
        assert property (tk && cmd_op == CMD_READ && cmd_otp && cmd_burst && cmd_word[2:0] == 3'h0
            |-> ##2 (rsp_valid_ff && !rsp_last_ff)[*7] ##1 rsp_valid_ff && rsp_last_ff)
            else $error("otp burst length");
    lock_set_a:
        assert property (tk && cmd_op == CMD_LOCK && !cmd_otp && cmd_slot == SLOT_GENERAL
            |-> ##[1:2] slot8_locked_ff) else $error("lock not set");
    burst_c: cover property (rsp_last_ff && rsp_valid_ff && $past(rsp_valid_ff));
    lock_c: cover property ($rose(slot8_locked_ff));
    sleep_c: cover property ($fell(scratch_key_valid_ff));
endmodule : slot_policy_props
bind secure_slot_access_policy slot_policy_props props_u (.clk, .rst, .cmd_valid, .cmd_otp,
    .cmd_burst, .sleep_req, .cmd_op, .cmd_slot, .cmd_word, .cmd_ready_ff, .rsp_valid_ff,
    .rsp_last_ff, .slot8_locked_ff, .otp_locked_ff, .scratch_key_valid_ff, .digest_valid_ff,
    .altkey_valid_ff, .hash_active_ff, .rsp_status_ff, .rsp_rdata_ff);

// ===== verif/slot_host_model.sv
// host model: issues one command, gathers the response words
// assumes the block's clock; command code {op,slot,word,mode,otp,burst}
`timescale 1ns/1ps
module slot_host_model (
    // clock
    input wire logic clk,
    // command and response
    output logic cmd_valid, cmd_otp, cmd_burst,
    output logic [1:0] cmd_mode, cmd_key,
    output logic [3:0] cmd_op, cmd_slot, cmd_word,
    output logic [31:0] cmd_wdata,
    input wire logic cmd_ready_ff, rsp_valid_ff, rsp_last_ff,
    input wire logic [7:0] rsp_status_ff,
    input wire logic [31:0] rsp_rdata_ff
);
    logic [7:0] st;
    logic [31:0] rd [8];
    int nw;
    initial begin
        {cmd_valid, cmd_otp, cmd_burst, cmd_mode, cmd_key, cmd_op, cmd_slot} = '0;
        {cmd_word, cmd_wdata} = '0;
    end
    task automatic send(input logic [15:0] c, input logic [31:0] d);
        int n;
        n = 0;
        nw = 0;
        st = 8'hxx;
        {cmd_op, cmd_slot, cmd_word, cmd_mode, cmd_otp, cmd_burst} <= c;
        {cmd_valid, cmd_key, cmd_wdata} <= {1'b1, c[7:6], d};
        @(posedge clk);
        while (!cmd_ready_ff) @(posedge clk);
        {cmd_valid, cmd_wdata} <= {1'b0, ~d};
        while (n < 12) begin
            @(posedge clk);
            n++;
            if (rsp_valid_ff) begin
                rd[nw[2:0]] = rsp_rdata_ff;
                st = rsp_status_ff;
                nw++;
                if (rsp_last_ff) n = 99;
            end
        end
    endtask : send
endmodule : slot_host_model

// ===== verif/secure_slot_access_policy_tb.sv
// self-checking bench for the slot policy block
// assumes host model and checker compile first
`timescale 1ns/1ps
module secure_slot_access_policy_tb;
    import slot_policy_pkg::*;
    logic clk, rst, sleep_req, cmd_valid, cmd_otp, cmd_burst, cmd_ready_ff, rsp_valid_ff;
    logic rsp_last_ff, slot8_locked_ff, otp_locked_ff, scratch_key_valid_ff, digest_valid_ff;
    logic altkey_valid_ff, hash_active_ff;
    logic [1:0] cmd_mode, cmd_key;
    logic [3:0] cmd_op, cmd_slot, cmd_word, w;
    logic [31:0] cmd_wdata, rsp_rdata_ff, d, e, h;
    logic [7:0] rsp_status_ff;
    int num_errors = 0, n_tests = 0, seed = 37978, i;
    function automatic logic [511:0] img();
        for (int k = 0; k < 16; k++) img[32*k+:32] = (32'h01010101 * (k + 1)) ^ 32'ha5000000;
    endfunction : img
    localparam logic [511:0] IMG = img();
    secure_slot_access_policy #(.OTP_IMAGE(IMG)) dut_u (.clk, .rst, .cmd_valid, .cmd_op,
        .cmd_mode, .cmd_otp, .cmd_slot, .cmd_word, .cmd_key, .cmd_burst, .cmd_wdata,
        .cmd_ready_ff, .rsp_valid_ff, .rsp_last_ff, .rsp_status_ff, .rsp_rdata_ff, .sleep_req,
        .slot8_locked_ff, .otp_locked_ff, .scratch_key_valid_ff, .digest_valid_ff,
        .altkey_valid_ff, .hash_active_ff);
    slot_host_model host_u (.clk, .cmd_valid, .cmd_otp, .cmd_burst, .cmd_mode, .cmd_key,
        .cmd_op, .cmd_slot, .cmd_word, .cmd_wdata, .cmd_ready_ff, .rsp_valid_ff,
        .rsp_last_ff, .rsp_status_ff, .rsp_rdata_ff);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic sc(input logic [15:0] c, input logic [31:0] v, input logic [7:0] es);
        host_u.send(c, v);
        chk(32'(host_u.st), 32'(es));
    endtask : sc
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        #60000;
        num_errors++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        sleep_req = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(otp_locked_ff), 32'h1);
        // slot 8 round trips, then slot 9 keys
        for (i = 0; i < 4; i++) begin
            e = $random(seed);
            w = 4'($random(seed));
            sc({8'h18, w, 4'h0}, e, STATUS_OK);
            sc({8'h08, w, 4'h0}, ~e, STATUS_OK);
            chk(host_u.rd[0], e);
        end
        for (i = 0; i < 16; i++) begin
            sc({8'h19, 4'(i), 4'h0}, $random(seed), STATUS_OK);
            sc({8'h09, 4'(i), 4'h0}, 32'h0, STATUS_DENIED);
        end
        sc(16'h59f0, 32'h0, STATUS_OK);
        sc(16'h4920, 32'h0, STATUS_OK);
        chk(host_u.rd[0], 32'h0);
        chk(32'(scratch_key_valid_ff), 32'h1);
        sc(16'h8800, 32'h0, STATUS_DENIED);
        sc(16'h8900, 32'h0, STATUS_DENIED);
        // certificate and signer key slots 10 to 12, and public key
        for (i = 10; i < 13; i++) begin
            sc({4'h1, 4'(i), 8'h00}, 32'h0, STATUS_DENIED);
            sc({4'h0, 4'(i), 8'h00}, 32'h0, STATUS_OK);
            sc({4'h4, 4'(i), 8'h10}, 32'h0, STATUS_OK);
        end
        sc(16'h7b00, 32'h0, STATUS_OK);
        // otp zone
        sc(16'h1032, 32'h0, STATUS_DENIED);
        for (i = 0; i < 16; i += 8) begin
            sc({8'h00, 4'(i), 4'h3}, 32'h0, STATUS_OK);
            chk(32'(host_u.nw), 32'h8);
            for (int k = 0; k < 8; k++) chk(host_u.rd[k], IMG[32*(i+k)+:32]);
        end
        sc(16'h00d2, 32'h0, STATUS_OK);
        chk(host_u.rd[0], IMG[32*13+:32]);
        sc(16'h0033, 32'h0, STATUS_PARSE);
        // hash phases, digest buffer, alternate key
        h = HASH_IV;
        sc(16'h9000, 32'h0, STATUS_OK);
        for (i = 0; i < 3; i++) begin
            d = $random(seed);
            h = {h[26:0], h[31:27]} ^ d;
            sc(16'h9004, d, STATUS_OK);
        end
        sc(16'h900c, 32'h0, STATUS_OK);
        chk(host_u.rd[0], h);
        sc(16'h9000, 32'h0, STATUS_OK);
        sc(16'h9008, 32'h0, STATUS_OK);
        sc(16'h6b00, 32'h0, STATUS_OK);
        sc(16'ha010, $random(seed), STATUS_OK);
        sc(16'hb010, 32'h0, STATUS_OK);
        @(posedge clk);
        chk(32'({digest_valid_ff, altkey_valid_ff}), 32'h3);
        sc(16'h9000, 32'h0, STATUS_OK);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(posedge clk);
        chk(32'({scratch_key_valid_ff, digest_valid_ff}), 32'h0);
        chk(32'({altkey_valid_ff, hash_active_ff}), 32'h0);
        sc(16'h9004, 32'h0, STATUS_DENIED);
        sc(16'hb010, 32'h0, STATUS_DENIED);
        // lock slot 8, refused write keeps data
        sc(16'h3800, 32'h0, STATUS_OK);
        sc(16'h2800, 32'h0, STATUS_OK);
        @(posedge clk);
        chk(32'(slot8_locked_ff), 32'h1);
        sc({8'h18, w, 4'h0}, ~e, STATUS_DENIED);
        sc({8'h08, w, 4'h0}, 32'h0, STATUS_OK);
        chk(host_u.rd[0], e);
        sc(16'hf800, 32'h0, STATUS_PARSE);
        close_out();
    end
endmodule : secure_slot_access_policy_tb
